// *** design/spdif_rx_status_interrupt.sv ***
// Receiver status, interrupt cause latch and mask for the audio receiver
`timescale 1ns/10ps
`include "spdif_irq_defs.svh"

module spdif_rx_status_interrupt (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Receiver flags, from the recovered-clock side
  input  wire logic                  unlock_flag,
  input  wire logic                  invalid_flag,
  input  wire logic                  parity_error,
  input  wire logic                  biphase_error,
  input  wire logic                  subframe_seq_error,
  input  wire logic                  chstat_nonpcm,
  input  wire logic                  burst_sync_detected,
  input  wire logic                  copyright_off,
  input  wire logic                  preemph_flag,
  input  wire logic                  chan_stat_block_updated,
  input  wire logic [1:0]            recovered_rate,
  // Register access port from the serial control decoder
  input  wire logic [`RA_W-1:0]      reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [`RD_W-1:0]      reg_wdata,
  input  wire logic                  reg_rd,
  output logic      [`RD_W-1:0]      reg_rdata,
  output logic                       reg_rvalid,
  // Interrupt line to the host, active low
  output logic                       irq_n_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Address match for a register access
  function automatic logic addr_hit(input logic [`RA_W-1:0] addr,
                                    input logic [`RA_W-1:0] target);
    addr_hit = (addr == target);
  endfunction

  // Level change between two samples
  function automatic logic changed(input logic now_v, input logic was_v);
    changed = now_v ^ was_v;
  endfunction

  // Low to high transition between two samples
  function automatic logic rose(input logic now_v, input logic was_v);
    rose = now_v & ~was_v;
  endfunction

  // Frame error is any of the three frame faults, judged after the sync
  function automatic logic frame_fault(input logic [`FLAGS_W-1:0] f);
    frame_fault = f[`FV_PARITY] | f[`FV_BIPHASE] | f[`FV_SEQ_ERR];
  endfunction

  // ----------------------------------------------------------------------
  // Flag gathering and synchronisation
  // ----------------------------------------------------------------------

  logic [`FLAGS_W-1:0] raw_flags;
  logic [`FLAGS_W-1:0] sync_flags;

  // Pack flags; the three frame faults cross in the same vector, so no logic
  // reads them before the second flop
  always_comb begin
    raw_flags                     = `FLAGS_RESET;
    raw_flags[`FV_UNLOCK]         = unlock_flag;
    raw_flags[`FV_INVALID]        = invalid_flag;
    raw_flags[`FV_BLOCK]          = chan_stat_block_updated;
    raw_flags[`FV_PARITY]         = parity_error;
    raw_flags[`FV_BIPHASE]        = biphase_error;
    raw_flags[`FV_SEQ_ERR]        = subframe_seq_error;
    raw_flags[`FV_CHSTAT_NONPCM]  = chstat_nonpcm;
    raw_flags[`FV_BURST_SYNC]     = burst_sync_detected;
    raw_flags[`FV_COPY_OFF]       = copyright_off;
    raw_flags[`FV_PREEMPH]        = preemph_flag;
    raw_flags[`FV_RATE_LO]        = recovered_rate[0];
    raw_flags[`FV_RATE_HI]        = recovered_rate[1];
  end

  // Receiver flags run on the recovered clock, so they cross here
  flag_sync u_flag_sync (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .async_flags (raw_flags),
    .sync_flags  (sync_flags)
  );

  // ----------------------------------------------------------------------
  // Start-up sequencing
  // ----------------------------------------------------------------------

  spdif_irq_pkg::watch_state_t state_q;
  spdif_irq_pkg::watch_state_t state_d;
  logic [1:0]                  settle_q;
  logic [1:0]                  settle_d;
  logic                        watching;

  // Edges are ignored until the synchroniser holds real samples,
  // otherwise reset zeros would look like a change on every flag that is high
  always_comb begin
    state_d  = state_q;
    settle_d = settle_q;
    unique case (state_q)
      spdif_irq_pkg::ST_SETTLE: begin
        settle_d = settle_q + `SETTLE_ONE;
        if (settle_q == `SETTLE_CYCLES) begin
          state_d  = spdif_irq_pkg::ST_RUN;
          settle_d = `SETTLE_ZERO;
        end
      end
      spdif_irq_pkg::ST_RUN: begin
        settle_d = `SETTLE_ZERO;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q  <= spdif_irq_pkg::ST_SETTLE;
      settle_q <= `SETTLE_ZERO;
    end else begin
      state_q  <= state_d;
      settle_q <= settle_d;
    end
  end

  assign watching = (state_q == spdif_irq_pkg::ST_RUN);

  // ----------------------------------------------------------------------
  // Previous-sample register for edge and change detection
  // ----------------------------------------------------------------------

  logic [`FLAGS_W-1:0] prev_q;

  // Tracks the flags every cycle, including while settling
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prev_q <= `FLAGS_RESET;
    end else begin
      prev_q <= sync_flags;
    end
  end

  logic                frame_error_now;
  logic                frame_error_was;

  // Any corruption of the recovered frame counts as one frame error
  assign frame_error_now = frame_fault(sync_flags);
  assign frame_error_was = frame_fault(prev_q);

  // ----------------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------------

  logic [`MASK_W-1:0] mask_q;
  logic               mask_wr;

  assign mask_wr = reg_wr & addr_hit(reg_addr, `ADDR_IRQ_MASK);

  // One bit per source, 1 blocks that source from the cause register and the line
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mask_q <= `MASK_RESET;
    end else if (mask_wr) begin
      mask_q <= reg_wdata[`MASK_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------

  logic [`CAUSE_W-1:0] events;
  logic                nonpcm_evt;
  logic                burst_evt;
  logic                rate_evt;

  // Each half of the non-audio flag has its own mask bit; the cause bit
  // is the OR of their masked change events, so a change in either unmasked half raises it
  assign nonpcm_evt = changed(sync_flags[`FV_CHSTAT_NONPCM], prev_q[`FV_CHSTAT_NONPCM])
                      & ~mask_q[`MB_CHSTAT_NONPCM];
  assign burst_evt  = changed(sync_flags[`FV_BURST_SYNC], prev_q[`FV_BURST_SYNC])
                      & ~mask_q[`MB_BURST_SYNC];

  // A rate change in either code bit is one event
  assign rate_evt = changed(sync_flags[`FV_RATE_LO], prev_q[`FV_RATE_LO])
                    | changed(sync_flags[`FV_RATE_HI], prev_q[`FV_RATE_HI]);

  // Masked events, laid out as the cause register
  always_comb begin
    events = `CAUSE_RESET;
    if (watching) begin
      events[`CB_LOCK]     = changed(sync_flags[`FV_UNLOCK], prev_q[`FV_UNLOCK])
                             & ~mask_q[`MB_LOCK];
      events[`CB_VALID]    = rose(sync_flags[`FV_INVALID], prev_q[`FV_INVALID])
                             & ~mask_q[`MB_VALID];
      events[`CB_BLOCK]    = rose(sync_flags[`FV_BLOCK], prev_q[`FV_BLOCK])
                             & ~mask_q[`MB_BLOCK];
      events[`CB_FRAME]    = rose(frame_error_now, frame_error_was)
                             & ~mask_q[`MB_FRAME];
      events[`CB_NONAUDIO] = nonpcm_evt | burst_evt;
      events[`CB_COPY]     = changed(sync_flags[`FV_COPY_OFF], prev_q[`FV_COPY_OFF])
                             & ~mask_q[`MB_COPY];
      events[`CB_PREEMPH]  = changed(sync_flags[`FV_PREEMPH], prev_q[`FV_PREEMPH])
                             & ~mask_q[`MB_PREEMPH];
      events[`CB_RATE]     = rate_evt & ~mask_q[`MB_RATE];
    end
  end

  // ----------------------------------------------------------------------
  // Levels that survive a cause read
  // ----------------------------------------------------------------------

  logic [`CAUSE_W-1:0] held;

  // Validity, frame error and block update still high at the read are
  // reloaded, so the line does not release while the condition persists
  always_comb begin
    held = `CAUSE_RESET;
    if (watching) begin
      held[`CB_VALID] = sync_flags[`FV_INVALID] & ~mask_q[`MB_VALID];
      held[`CB_BLOCK] = sync_flags[`FV_BLOCK]   & ~mask_q[`MB_BLOCK];
      held[`CB_FRAME] = frame_error_now         & ~mask_q[`MB_FRAME];
    end
  end

  // ----------------------------------------------------------------------
  // Cause latch
  // ----------------------------------------------------------------------

  logic [`CAUSE_W-1:0] cause_q;
  logic [`CAUSE_W-1:0] cause_d;
  logic                cause_rd;

  // Host reads the cause register to find the source and clear it
  assign cause_rd = reg_rd & addr_hit(reg_addr, `ADDR_IRQ_CAUSE);

  // Sticky bits; a new event in the read cycle is ORed in after the
  // clear so it waits for the next read instead of being lost
  always_comb begin
    if (cause_rd) begin
      cause_d = held | events;
    end else begin
      cause_d = cause_q | events;
    end
  end

  // Cause register state; writes to it are ignored
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cause_q <= `CAUSE_RESET;
    end else begin
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------------

  // Low while any cause bit is set; follows the next cause state so the
  // line and the register never disagree
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_n_out <= 1'b1;
    end else begin
      irq_n_out <= ~(|cause_d);
    end
  end

  // ----------------------------------------------------------------------
  // Live status
  // ----------------------------------------------------------------------

  logic [`STATUS_W-1:0] live_status;

  // Built from synchronised flags, independent of the mask
  always_comb begin
    live_status                    = `STATUS_W'(0);
    live_status[`SB_CHSTAT_NONPCM] = sync_flags[`FV_CHSTAT_NONPCM];
    live_status[`SB_BURST_SYNC]    = sync_flags[`FV_BURST_SYNC];
    live_status[`SB_COPY_OFF]      = sync_flags[`FV_COPY_OFF];
    live_status[`SB_PREEMPH]       = sync_flags[`FV_PREEMPH];
    live_status[`SB_RATE_LO]       = sync_flags[`FV_RATE_LO];
    live_status[`SB_RATE_HI]       = sync_flags[`FV_RATE_HI];
    live_status[`SB_UNLOCK]        = sync_flags[`FV_UNLOCK];
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------

  logic [`RD_W-1:0] rdata_d;

  // Read mux; cause read returns the bits before the clear, unknown
  // addresses read as zero
  always_comb begin
    rdata_d = `RDATA_RESET;
    if (addr_hit(reg_addr, `ADDR_IRQ_MASK)) begin
      rdata_d = mask_q;
    end else if (addr_hit(reg_addr, `ADDR_IRQ_CAUSE)) begin
      rdata_d = {1'b0, cause_q};
    end else if (addr_hit(reg_addr, `ADDR_LIVE_STATUS)) begin
      rdata_d = {2'b00, live_status};
    end
  end

  // Read data and its strobe, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata  <= `RDATA_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

endmodule // spdif_rx_status_interrupt

// *** design/spdif_irq_defs.svh ***
// Constants for the receiver status and interrupt block
`ifndef SPDIF_IRQ_DEFS_SVH
`define SPDIF_IRQ_DEFS_SVH

// ----------------------------------------------------------------------
// Register port geometry
// ----------------------------------------------------------------------
`define RA_W              7
`define RD_W              9

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_IRQ_MASK     7'h25
`define ADDR_IRQ_CAUSE    7'h2b
`define ADDR_LIVE_STATUS  7'h31

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MASK_RESET        9'h000
`define CAUSE_RESET       8'h00
`define FLAGS_RESET       12'h000
`define RDATA_RESET       9'h000

// ----------------------------------------------------------------------
// Cause register bit positions
// ----------------------------------------------------------------------
`define CB_LOCK           0
`define CB_VALID          1
`define CB_BLOCK          2
`define CB_FRAME          3
`define CB_NONAUDIO       4
`define CB_COPY           5
`define CB_PREEMPH        6
`define CB_RATE           7
`define CAUSE_W           8

// ----------------------------------------------------------------------
// Mask register bit positions
// ----------------------------------------------------------------------
`define MB_LOCK           0
`define MB_VALID          1
`define MB_BLOCK          2
`define MB_FRAME          3
`define MB_CHSTAT_NONPCM  4
`define MB_BURST_SYNC     5
`define MB_COPY           6
`define MB_PREEMPH        7
`define MB_RATE           8
`define MASK_W            9

// ----------------------------------------------------------------------
// Live status register bit positions
// ----------------------------------------------------------------------
`define SB_CHSTAT_NONPCM  0
`define SB_BURST_SYNC     1
`define SB_COPY_OFF       2
`define SB_PREEMPH        3
`define SB_RATE_LO        4
`define SB_RATE_HI        5
`define SB_UNLOCK         6
`define STATUS_W          7

// ----------------------------------------------------------------------
// Synchronised flag vector layout
// ----------------------------------------------------------------------
`define FV_UNLOCK         0
`define FV_INVALID        1
`define FV_BLOCK          2
`define FV_PARITY         3
`define FV_CHSTAT_NONPCM  4
`define FV_BURST_SYNC     5
`define FV_COPY_OFF       6
`define FV_PREEMPH        7
`define FV_RATE_LO        8
`define FV_RATE_HI        9
`define FV_BIPHASE        10
`define FV_SEQ_ERR        11
`define FLAGS_W           12

// Cycles for the synchroniser to fill before edges are trusted
`define SETTLE_CYCLES     2'h3
`define SETTLE_ZERO       2'h0
`define SETTLE_ONE        2'h1

`endif

// *** design/spdif_irq_pkg.sv ***
// Types for the receiver status and interrupt block
package spdif_irq_pkg;

  // Start-up sequencing of the change detector
  typedef enum logic [0:0] {
    ST_SETTLE,
    ST_RUN
  } watch_state_t;

endpackage

// *** design/flag_sync.sv ***
// Two-stage synchroniser for the receiver flag vector
`timescale 1ns/10ps
`include "spdif_irq_defs.svh"

module flag_sync (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Flags from the receiver
  input  wire logic [`FLAGS_W-1:0]  async_flags,
  // Flags in the core clock domain
  output logic      [`FLAGS_W-1:0]  sync_flags
);

  logic [`FLAGS_W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_q     <= `FLAGS_RESET;
      sync_flags <= `FLAGS_RESET;
    end else begin
      meta_q     <= async_flags;
      sync_flags <= meta_q;
    end
  end

endmodule // flag_sync

// *** tb/spdif_rx_status_interrupt_assertions.sv ***
// Port-level checker for the receiver status and interrupt block
`timescale 1ns/10ps
`include "spdif_irq_defs.svh"

module spdif_rx_status_interrupt_checker (
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             rstn,
  // Receiver flags
  input wire logic             unlock_flag,
  input wire logic             invalid_flag,
  input wire logic             parity_error,
  input wire logic             biphase_error,
  input wire logic             subframe_seq_error,
  input wire logic             chstat_nonpcm,
  input wire logic             burst_sync_detected,
  input wire logic             copyright_off,
  input wire logic             preemph_flag,
  input wire logic             chan_stat_block_updated,
  input wire logic [1:0]       recovered_rate,
  // Register port
  input wire logic [`RA_W-1:0] reg_addr,
  input wire logic             reg_wr,
  input wire logic [`RD_W-1:0] reg_wdata,
  input wire logic             reg_rd,
  input wire logic [`RD_W-1:0] reg_rdata,
  input wire logic             reg_rvalid,
  // Interrupt
  input wire logic             irq_n_out
);
  logic [3:0]       stab_q;
  logic [3:0]       up_q;
  logic [`RD_W-1:0] mask_q;
  logic [11:0]      flags;
  logic             cause_rd;
  logic             mapped;

  // ----
  // Helpers
  // ----
  assign flags = {unlock_flag, invalid_flag, parity_error, biphase_error, subframe_seq_error,
                  chstat_nonpcm, burst_sync_detected, copyright_off, preemph_flag,
                  chan_stat_block_updated, recovered_rate};
  assign cause_rd = reg_rd && reg_addr == `ADDR_IRQ_CAUSE;
  assign mapped = reg_addr inside {`ADDR_IRQ_MASK, `ADDR_IRQ_CAUSE, `ADDR_LIVE_STATUS};

  // Cycles since flags last moved; status is only judged once the sync has filled
  always_ff @(posedge core_clk) begin
    if (!rstn || $changed(flags)) stab_q <= 4'h0;
    else if (stab_q != 4'hf) stab_q <= stab_q + 4'h1;
  end

  // Cycles since reset release; events in the settle window are dropped
  always_ff @(posedge core_clk) begin
    if (!rstn) up_q <= 4'h0;
    else if (up_q != 4'hf) up_q <= up_q + 4'h1;
  end

  // Shadow of the mask register
  always_ff @(posedge core_clk) begin
    if (!rstn) mask_q <= `MASK_RESET;
    else if (reg_wr && reg_addr == `ADDR_IRQ_MASK) mask_q <= reg_wdata;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ----
  // Assertions
  // ----
  rvalid_pulse_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  answer_only_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  irq_hold_a: assert property (!irq_n_out && !cause_rd |=> !irq_n_out)
    else $error("interrupt released without cause read");
  irq_release_a: assert property ($rose(irq_n_out) |-> $past(cause_rd))
    else $error("interrupt rose without cause read");
  status_map_a: assert property (reg_rd && reg_addr == `ADDR_LIVE_STATUS && stab_q > 4'h3
    |=> reg_rdata == {2'h0, $past(unlock_flag), $past(recovered_rate), $past(preemph_flag),
                      $past(copyright_off), $past(burst_sync_detected), $past(chstat_nonpcm)})
    else $error("live status field mismatch");
  unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 9'h000)
    else $error("unmapped read not zero");
  mask_readback_a: assert property (reg_rd && !reg_wr && reg_addr == `ADDR_IRQ_MASK
    |=> reg_rdata == $past(mask_q))
    else $error("mask readback mismatch");
  rate_irq_a: assert property ($changed(recovered_rate) && !mask_q[8] && up_q == 4'hf
    |-> ##[1:5] !irq_n_out)
    else $error("rate change raised no interrupt");
  cause_width_a: assert property (reg_rvalid && $past(reg_addr) == `ADDR_IRQ_CAUSE
    |-> !reg_rdata[8])
    else $error("cause read top bit set");

  irq_seen_c: cover property (!irq_n_out);
  level_kept_c: cover property (cause_rd ##1 !irq_n_out);
  mask_write_c: cover property (reg_wr && reg_addr == `ADDR_IRQ_MASK);
endmodule // spdif_rx_status_interrupt_checker

// *** tb/host_model.sv ***
// Host model driving the register port of the receiver status block
`timescale 1ns/10ps
`include "spdif_irq_defs.svh"

module host_model (
  // Clock
  input  wire logic             core_clk,
  // Register port towards the block
  output logic      [`RA_W-1:0] reg_addr,
  output logic                  reg_wr,
  output logic      [`RD_W-1:0] reg_wdata,
  output logic                  reg_rd,
  input  wire logic [`RD_W-1:0] reg_rdata,
  input  wire logic             reg_rvalid
);
  // Idle values; write data idles inverted so a stale word never matches
  initial begin
    reg_addr  = 7'h00;
    reg_wr    = 1'b0;
    reg_wdata = 9'h1ff;
    reg_rd    = 1'b0;
  end

  // One-cycle write strobe
  task automatic wr(input logic [`RA_W-1:0] a, input logic [`RD_W-1:0] d);
    @(posedge core_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // One-cycle read strobe; the answer stands only in the following cycle
  task automatic rd(input logic [`RA_W-1:0] a, output logic [`RD_W-1:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    d      = reg_rvalid ? reg_rdata : 'x; // No answer shows up as a miscompare
  endtask
endmodule // host_model

// *** tb/test_spdif_rx_status_interrupt.sv ***
// Self-checking bench for the receiver status and interrupt block
`timescale 1ns/10ps
`include "spdif_irq_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_spdif_rx_status_interrupt;
  logic             core_clk    = 1'b0;
  logic             rstn        = 1'b0;
  logic [11:0]      v           = 12'h800;  // Flags; rate code in 11:10
  logic [`RA_W-1:0] reg_addr;
  logic             reg_wr;
  logic [`RD_W-1:0] reg_wdata;
  logic             reg_rd;
  logic [`RD_W-1:0] reg_rdata;
  logic             reg_rvalid;
  logic             irq_n_out;
  logic [8:0]       d;
  logic [8:0]       acc;
  int               miscompares = 0;
  int               checks_done = 0;
  // Per flag index: cause bit, mask bit, and whether it is a level source
  int               cb [10]     = '{0, 1, 3, 3, 3, 4, 4, 5, 6, 2};
  int               mb [10]     = '{0, 1, 3, 3, 3, 4, 5, 6, 7, 2};
  logic [9:0]       lvl         = 10'h21e;

  always #12.5 core_clk = ~core_clk;

  host_model host (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
                   .reg_rvalid);

  spdif_rx_status_interrupt dut (
    .core_clk, .rstn, .unlock_flag(v[0]), .invalid_flag(v[1]), .parity_error(v[2]),
    .biphase_error(v[3]), .subframe_seq_error(v[4]), .chstat_nonpcm(v[5]),
    .burst_sync_detected(v[6]), .copyright_off(v[7]), .preemph_flag(v[8]),
    .chan_stat_block_updated(v[9]), .recovered_rate(v[11:10]), .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .irq_n_out);

  task automatic summarize();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    cyc(10);
    rstn = 1'b1;
    cyc(10); // Let the synchroniser fill before any event
  endtask

  // Wait out the event path, then check status, cause and the line after the read
  task automatic step(input logic [7:0] ec, input logic lv);
    logic [8:0] s;
    cyc(8);
    `CHK(irq_n_out, ec == 8'h00)
    host.rd(`ADDR_LIVE_STATUS, s);
    `CHK(s, {2'h0, v[0], v[11:10], v[8], v[7], v[6], v[5]})
    host.rd(`ADDR_IRQ_CAUSE, s);
    `CHK(s, {1'b0, ec})
    `CHK(irq_n_out, !lv)
  endtask

  // Toggle every flag up and down, then walk all four rate codes, under one mask
  task automatic pass(input logic [8:0] m);
    logic [7:0] ec;
    logic [8:0] s;
    host.wr(`ADDR_IRQ_MASK, m);
    host.rd(`ADDR_IRQ_MASK, s);
    `CHK(s, m)
    for (int i = 0; i < 10; i++) begin
      ec   = m[mb[i]] ? 8'h00 : 8'h01 << cb[i];
      v[i] = 1'b1;
      step(ec, lvl[i] && !m[mb[i]]);
      v[i] = 1'b0;
      step(ec, 1'b0);
    end
    for (int r = 0; r < 4; r++) begin
      v[11:10] = v[11:10] + 2'h1;
      step(m[8] ? 8'h00 : 8'h80, 1'b0);
    end
  endtask

  // Cut a hang short
  initial begin
    #400000;
    miscompares++;
    summarize();
  end

  initial begin
    do_reset();
    host.rd(`ADDR_IRQ_MASK, d);
    `CHK(d, `MASK_RESET)
    step(8'h00, 1'b0);
    // None, whole set, then two halves that split the two non-audio mask bits
    pass(9'h000);
    pass(9'h1ff);
    pass(9'h155);
    pass(9'h0aa);
    host.wr(`ADDR_IRQ_MASK, 9'h000);
    // Reads back to back, the event landing on a read edge; it must surface in at least one read
    v[0] = 1'b1;
    cyc(1);
    acc  = 9'h000;
    repeat (6) begin
      host.rd(`ADDR_IRQ_CAUSE, d);
      acc = acc | d;
    end
    `CHK(acc, 9'h001)
    `CHK(irq_n_out, 1'b1)
    v[0] = 1'b0;
    step(8'h01, 1'b0);
    // Writes to read-only and unmapped places change nothing
    host.wr(`ADDR_IRQ_CAUSE, 9'h0ff);
    host.wr(`ADDR_LIVE_STATUS, 9'h1ff);
    host.wr(7'h00, 9'h1ff);
    step(8'h00, 1'b0);
    host.rd(7'h00, d);
    `CHK(d, 9'h000)
    host.rd(`ADDR_IRQ_MASK, d);
    `CHK(d, 9'h000)
    // A reset in mid-run clears the mask
    host.wr(`ADDR_IRQ_MASK, 9'h1ff);
    do_reset();
    host.rd(`ADDR_IRQ_MASK, d);
    `CHK(d, `MASK_RESET)
    step(8'h00, 1'b0);
    summarize();
  end
endmodule // test_spdif_rx_status_interrupt

bind spdif_rx_status_interrupt spdif_rx_status_interrupt_checker chk (
  .core_clk, .rstn, .unlock_flag, .invalid_flag, .parity_error, .biphase_error,
  .subframe_seq_error, .chstat_nonpcm, .burst_sync_detected, .copyright_off, .preemph_flag,
  .chan_stat_block_updated, .recovered_rate, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .reg_rvalid, .irq_n_out);
